// >>> src/tss_pkg.sv
// Purpose: shared constants and types for the trigger step sequencer
// Assumes: 32-bit AXI4-Lite register port, byte addresses below 0x80
// Notes: opcode field is the upper nibble of a step, argument the lower
package tss_pkg;
	localparam int ADDR_W = 8;
	localparam int QDEPTH = 8;
	localparam int NTRIG = 4;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SDLIM = 8'h04;
	localparam logic [7:0] OFF_C0LIM = 8'h08;
	localparam logic [7:0] OFF_C1LIM = 8'h0c;
	localparam logic [7:0] OFF_T0LIM = 8'h10;
	localparam logic [7:0] OFF_T1LIM = 8'h14;
	localparam logic [7:0] OFF_ISTAT = 8'h18;
	localparam logic [7:0] OFF_ICLR = 8'h1c;
	localparam logic [7:0] OFF_IEN = 8'h20;
	localparam logic [7:0] OFF_STAT = 8'h24;
	localparam logic [7:0] OFF_WDLIM = 8'h28;
	localparam logic [7:0] OFF_CNT = 8'h2c;
	localparam logic [7:0] OFF_QUEUE = 8'h40;

	// control bit positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_RUN = 1;
	localparam int CTRL_SSTEP = 2;
	localparam int CTRL_FALL = 3;

	// interrupt status bit positions
	localparam int IST_W = 6;
	localparam int IST_SSTEP = 4;
	localparam int IST_WDT = 5;

	// reset values
	localparam logic [15:0] RST_LIM = 16'h0000;
	localparam logic [7:0] RST_STEP = 8'h00;

	// step opcodes
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_WAIT_TRIG = 4'h1;
	localparam logic [3:0] OP_OUT_TRIG = 4'h2;
	localparam logic [3:0] OP_IRQ = 4'h3;
	localparam logic [3:0] OP_WAIT_TMR = 4'h4;
	localparam logic [3:0] OP_JMP_CNT = 4'h5;
	localparam logic [3:0] OP_JMP = 4'h7;
	localparam logic [3:0] OP_HALT = 4'h8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_DELAY = 3'b100
	} tss_state_t;
endpackage

// >>> src/tss_sequencer.sv
// Purpose: trigger step sequencer with AXI4-Lite registers
// Assumes: trigger inputs synchronous to aclk; ce freezes everything
// Notes: a step starts in the cycle its action fires; waits do not count
`timescale 1ns/10ps
`default_nettype none

module tss_sequencer (
	input wire logic aclk, // clock, 250 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [3:0] trig_in, // peripheral trigger inputs
	output logic [3:0] trig_out, // peripheral trigger pulses
	output logic [3:0] step_irq, // per-source processor interrupts
	output logic irq // combined interrupt, level
);
	// word-aligned address match, used by both bus paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// merge write data into a 16-bit register by byte enables
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	tss_pkg::tss_state_t st_r;
	logic [3:0] ctrl_r;
	logic [15:0] sdlim_r, wdlim_r, dly_r, wdt_r;
	logic [15:0] clim_r [2];
	logic [15:0] cnt_r [2];
	logic [15:0] tlim_r [2];
	logic [15:0] tmr_r [2];
	logic [7:0] queue_r [tss_pkg::QDEPTH];
	logic [2:0] ptr_r, ptr_nxt;
	logic [tss_pkg::IST_W-1:0] ist_r, ien_r, ist_set;
	logic [3:0] trig_prev_r, trig_edge, trig_out_r;
	logic [7:0] awaddr_r, wr_addr;
	logic [31:0] wdata_r, wr_data, rdata_r;
	logic [3:0] wstrb_r, wr_strb;
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic aw_fire, w_fire, wr_do, wr_ok, ar_fire;
	logic active, step_done, wdt_trip, halt_step;
	logic [7:0] step_w;
	logic [3:0] opc_w, arg_w;
	logic [31:0] rd_val;
	logic rd_ok;

	// address, data and read request handshakes carry ce so no request is taken while frozen; bvalid and rvalid are not gated
	assign s_axi_awready = ce & ~aw_got_r & ~bvalid_r;
	assign s_axi_wready = ce & ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ce & ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
	assign wr_data = w_got_r ? wdata_r : s_axi_wdata;
	assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
	assign wr_do = ce & (aw_got_r | aw_fire) & (w_got_r | w_fire);

	// address and data may arrive in either order; hold the early one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else if (ce) begin
			if (wr_do) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end else begin
				if (aw_fire) begin
					aw_got_r <= 1'b1;
					awaddr_r <= s_axi_awaddr;
				end
				if (w_fire) begin
					w_got_r <= 1'b1;
					wdata_r <= s_axi_wdata;
					wstrb_r <= s_axi_wstrb;
				end
			end
		end
	end

	// unmapped writes still complete, with an error response
	assign wr_ok = hit(wr_addr, tss_pkg::OFF_CTRL) | hit(wr_addr, tss_pkg::OFF_SDLIM)
		| hit(wr_addr, tss_pkg::OFF_C0LIM) | hit(wr_addr, tss_pkg::OFF_C1LIM)
		| hit(wr_addr, tss_pkg::OFF_T0LIM) | hit(wr_addr, tss_pkg::OFF_T1LIM)
		| hit(wr_addr, tss_pkg::OFF_ICLR) | hit(wr_addr, tss_pkg::OFF_IEN)
		| hit(wr_addr, tss_pkg::OFF_WDLIM) | (wr_addr[7:5] == tss_pkg::OFF_QUEUE[7:5])
		| hit(wr_addr, tss_pkg::OFF_ISTAT) | hit(wr_addr, tss_pkg::OFF_STAT) | hit(wr_addr, tss_pkg::OFF_CNT);

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= tss_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? tss_pkg::RESP_OKAY : tss_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read decode
	always_comb begin
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		if (hit(s_axi_araddr, tss_pkg::OFF_CTRL)) rd_val = {28'h0000000, ctrl_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_SDLIM)) rd_val = {16'h0000, sdlim_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_C0LIM)) rd_val = {16'h0000, clim_r[0]};
		else if (hit(s_axi_araddr, tss_pkg::OFF_C1LIM)) rd_val = {16'h0000, clim_r[1]};
		else if (hit(s_axi_araddr, tss_pkg::OFF_T0LIM)) rd_val = {16'h0000, tlim_r[0]};
		else if (hit(s_axi_araddr, tss_pkg::OFF_T1LIM)) rd_val = {16'h0000, tlim_r[1]};
		else if (hit(s_axi_araddr, tss_pkg::OFF_ISTAT)) rd_val = {26'h0000000, ist_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_ICLR)) rd_val = 32'h00000000;
		else if (hit(s_axi_araddr, tss_pkg::OFF_IEN)) rd_val = {26'h0000000, ien_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_STAT)) rd_val = {25'h0000000, st_r, 1'b0, ptr_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_WDLIM)) rd_val = {16'h0000, wdlim_r};
		else if (hit(s_axi_araddr, tss_pkg::OFF_CNT)) rd_val = {cnt_r[1], cnt_r[0]};
		else if (s_axi_araddr[7:5] == tss_pkg::OFF_QUEUE[7:5]) rd_val = {24'h000000, queue_r[s_axi_araddr[4:2]]};
		else rd_ok = 1'b0;
	end

	// read response, data registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= tss_pkg::RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_ok ? tss_pkg::RESP_OKAY : tss_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign active = ctrl_r[tss_pkg::CTRL_EN] & ctrl_r[tss_pkg::CTRL_RUN];

	// control; a software write of run beats the hardware clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= 4'h0;
		end else if (ce) begin
			if (wr_do && hit(wr_addr, tss_pkg::OFF_CTRL) && wr_strb[0]) begin
				ctrl_r <= wr_data[3:0];
			end else if (st_r == tss_pkg::ST_EXEC && (wdt_trip || (step_done && halt_step))) begin
				ctrl_r[tss_pkg::CTRL_RUN] <= 1'b0;
			end
		end
	end

	// limits; delay and counter 0 limits lock while running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sdlim_r <= tss_pkg::RST_LIM;
			clim_r[0] <= tss_pkg::RST_LIM;
			clim_r[1] <= tss_pkg::RST_LIM;
			tlim_r[0] <= tss_pkg::RST_LIM;
			tlim_r[1] <= tss_pkg::RST_LIM;
			wdlim_r <= tss_pkg::RST_LIM;
			ien_r <= '0;
		end else if (ce && wr_do) begin
			if (hit(wr_addr, tss_pkg::OFF_SDLIM) && !active) sdlim_r <= merge16(sdlim_r, wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_C0LIM) && !active) clim_r[0] <= merge16(clim_r[0], wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_C1LIM)) clim_r[1] <= merge16(clim_r[1], wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_T0LIM)) tlim_r[0] <= merge16(tlim_r[0], wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_T1LIM)) tlim_r[1] <= merge16(tlim_r[1], wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_WDLIM)) wdlim_r <= merge16(wdlim_r, wr_data, wr_strb);
			if (hit(wr_addr, tss_pkg::OFF_IEN) && wr_strb[0]) ien_r <= wr_data[tss_pkg::IST_W-1:0];
		end
	end

	// step queue storage, written a byte at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < tss_pkg::QDEPTH; i++) queue_r[i] <= tss_pkg::RST_STEP;
		end else if (ce && wr_do && wr_addr[7:5] == tss_pkg::OFF_QUEUE[7:5] && wr_strb[0]) begin
			queue_r[wr_addr[4:2]] <= wr_data[7:0];
		end
	end

	// edge detect on triggers, polarity from control
	always_ff @(posedge aclk) begin
		if (!aresetn) trig_prev_r <= 4'h0;
		else if (ce) trig_prev_r <= trig_in;
	end
	assign trig_edge = ctrl_r[tss_pkg::CTRL_FALL] ? (trig_prev_r & ~trig_in) : (~trig_prev_r & trig_in);

	// current step decode
	assign step_w = queue_r[ptr_r];
	assign opc_w = step_w[7:4];
	assign arg_w = step_w[3:0];
	assign halt_step = (opc_w == tss_pkg::OP_HALT);
	assign wdt_trip = (wdlim_r != 16'h0000) && (wdt_r == wdlim_r) && (st_r == tss_pkg::ST_EXEC);

	// a step fires at once unless it waits on a trigger or a timer
	always_comb begin
		step_done = 1'b1;
		ptr_nxt = ptr_r + 3'h1;
		unique case (opc_w)
			tss_pkg::OP_WAIT_TRIG: step_done = trig_edge[arg_w[1:0]];
			tss_pkg::OP_WAIT_TMR: step_done = (tmr_r[arg_w[0]] == tlim_r[arg_w[0]]);
			tss_pkg::OP_JMP: ptr_nxt = arg_w[2:0];
			tss_pkg::OP_JMP_CNT: if (cnt_r[arg_w[3]] != clim_r[arg_w[3]]) ptr_nxt = arg_w[2:0];
			default: step_done = 1'b1;
		endcase
	end

	// sequencing: exec cycle plus delay limit cycles per step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= tss_pkg::ST_IDLE;
			ptr_r <= 3'h0;
			dly_r <= 16'h0000;
		end else if (ce) begin
			unique case (st_r)
				tss_pkg::ST_IDLE: begin
					ptr_r <= 3'h0;
					if (active) st_r <= tss_pkg::ST_EXEC;
				end
				tss_pkg::ST_EXEC: begin
					if (!active || wdt_trip) begin
						st_r <= tss_pkg::ST_IDLE;
					end else if (step_done) begin
						ptr_r <= ptr_nxt;
						dly_r <= sdlim_r;
						if (halt_step) st_r <= tss_pkg::ST_IDLE;
						else if (sdlim_r != 16'h0000) st_r <= tss_pkg::ST_DELAY;
					end
				end
				tss_pkg::ST_DELAY: begin
					dly_r <= dly_r - 16'h0001;
					if (!active) st_r <= tss_pkg::ST_IDLE;
					else if (dly_r == 16'h0001) st_r <= tss_pkg::ST_EXEC;
				end
			endcase
		end
	end

	// timers and loop counters, one pair each
	for (genvar g = 0; g < 2; g++) begin : g_cnt
		always_ff @(posedge aclk) begin
			if (!aresetn || (ce && st_r == tss_pkg::ST_IDLE)) begin
				cnt_r[g] <= 16'h0000;
			end else if (ce && st_r == tss_pkg::ST_EXEC && step_done && opc_w == tss_pkg::OP_JMP_CNT
				&& arg_w[3] == 1'(g) && active && !wdt_trip) begin
				cnt_r[g] <= (cnt_r[g] == clim_r[g]) ? 16'h0000 : cnt_r[g] + 16'h0001;
			end
		end
		// a timer runs only while a step waits on it, so each wait starts fresh
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tmr_r[g] <= 16'h0000;
			end else if (ce) begin
				if (st_r == tss_pkg::ST_EXEC && opc_w == tss_pkg::OP_WAIT_TMR && arg_w[0] == 1'(g) && !step_done)
					tmr_r[g] <= tmr_r[g] + 16'h0001;
				else
					tmr_r[g] <= 16'h0000;
			end
		end
	end

	// watchdog counts cycles spent waiting in one step
	always_ff @(posedge aclk) begin
		if (!aresetn) wdt_r <= 16'h0000;
		else if (ce) wdt_r <= (st_r == tss_pkg::ST_EXEC && !step_done && !wdt_trip) ? wdt_r + 16'h0001 : 16'h0000;
	end

	// output trigger pulses, one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) trig_out_r <= 4'h0;
		else if (ce) trig_out_r <= (st_r == tss_pkg::ST_EXEC && active && !wdt_trip && opc_w == tss_pkg::OP_OUT_TRIG)
			? (4'h1 << arg_w[1:0]) : 4'h0;
	end
	assign trig_out = trig_out_r;

	// interrupt sources
	always_comb begin
		ist_set = '0;
		if (st_r == tss_pkg::ST_EXEC && active && !wdt_trip && step_done) begin
			if (opc_w == tss_pkg::OP_IRQ) ist_set[arg_w[1:0]] = 1'b1;
			if (ctrl_r[tss_pkg::CTRL_SSTEP]) ist_set[tss_pkg::IST_SSTEP] = 1'b1;
		end
		if (wdt_trip && active) ist_set[tss_pkg::IST_WDT] = 1'b1;
	end

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_r <= '0;
		end else if (ce) begin
			if (wr_do && hit(wr_addr, tss_pkg::OFF_ICLR) && wr_strb[0])
				ist_r <= (ist_r & ~wr_data[tss_pkg::IST_W-1:0]) | ist_set;
			else
				ist_r <= ist_r | ist_set;
		end
	end
	assign irq = |(ist_r & ien_r);
	assign step_irq = ist_r[3:0] & ien_r[3:0];

	a_delay_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && st_r == tss_pkg::ST_EXEC && active && !wdt_trip && step_done && !halt_step && sdlim_r == 16'h0000)
		|=> (!ce || st_r == tss_pkg::ST_EXEC)) else $error("zero delay step left exec");
	a_delay_one: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && st_r == tss_pkg::ST_EXEC && active && !wdt_trip && step_done && !halt_step && sdlim_r == 16'h0001)
		##1 (ce && active) |-> st_r == tss_pkg::ST_DELAY ##1 st_r == tss_pkg::ST_EXEC) else $error("step length wrong");
	a_sdlim_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(active && wr_do && hit(wr_addr, tss_pkg::OFF_SDLIM)) |=> $stable(sdlim_r)) else $error("delay limit written while running");
	a_c0lim_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(active && wr_do && hit(wr_addr, tss_pkg::OFF_C0LIM)) |=> $stable(clim_r[0])) else $error("counter limit written while running");
	a_trig_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && st_r == tss_pkg::ST_EXEC && active && !wdt_trip && opc_w == tss_pkg::OP_WAIT_TRIG && !trig_edge[arg_w[1:0]])
		|=> st_r == tss_pkg::ST_EXEC && $stable(ptr_r)) else $error("trigger wait did not hold");
	a_irq_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && st_r == tss_pkg::ST_EXEC && active && !wdt_trip && opc_w == tss_pkg::OP_IRQ)
		|=> ist_r[$past(arg_w[1:0])]) else $error("interrupt step not flagged");
	a_sstep_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && st_r == tss_pkg::ST_EXEC && active && !wdt_trip && step_done && ctrl_r[tss_pkg::CTRL_SSTEP])
		|=> ist_r[tss_pkg::IST_SSTEP]) else $error("single step event lost");
	a_wdt_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && wdt_trip && active) |=> ist_r[tss_pkg::IST_WDT] && st_r == tss_pkg::ST_IDLE) else $error("watchdog not handled");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule

`default_nettype wire

// >>> verif/tss_periph_model.sv
// Purpose: peripheral side of the trigger lines, drives inputs, tallies output pulses
// Assumes: one clock; trigger levels change only just after a rising edge
// Notes: pulse counts only grow, so callers compare against a snapshot
`timescale 1ns/10ps
`default_nettype none
module tss_periph_model (
	input wire logic aclk, // sequencer clock
	input wire logic [3:0] trig_out, // pulses from the sequencer
	output logic [3:0] trig_in // trigger levels to the sequencer
);
	int cyc;
	int pulse_cnt [4];
	int last_cyc [4];
	initial trig_in = 4'h0;
	// cycle stamp and tally of every pulse, one bucket per line
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 4; i++) begin
			if (trig_out[i] === 1'b1) begin
				pulse_cnt[i] <= pulse_cnt[i] + 1;
				last_cyc[i] <= cyc;
			end
		end
	end
	// level change lands on a rising edge, never between edges
	task automatic set_trig(input int idx, input logic val);
		@(posedge aclk);
		trig_in[idx] <= val;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_trigger_step_sequencer.sv
// Purpose: register level tests of the trigger step sequencer
// Assumes: ce held high, full word strobes, limits written while stopped except in the lock test, which writes them while running
// Notes: every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/10ps
`default_nettype none
module tb_trigger_step_sequencer;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [3:0] trig_in, trig_out, step_irq;
	int fail_count, checks_done, base;
	logic [31:0] d;
	logic [1:0] r;
	logic [7:0] lim_offs [5] = '{tss_pkg::OFF_SDLIM, tss_pkg::OFF_C0LIM, tss_pkg::OFF_C1LIM,
		tss_pkg::OFF_T0LIM, tss_pkg::OFF_T1LIM};

	tss_sequencer uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .trig_in, .trig_out, .step_irq, .irq);
	tss_periph_model periph (.aclk, .trig_out, .trig_in);

	// 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic timeout(input string name);
		fail_count++;
		$display("[FAIL] %s expected answer seen timeout", name);
		end_sim();
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
		int n;
		logic aw_d, w_d, done;
		aw_d = 1'b0;
		w_d = 1'b0;
		done = 1'b0;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= wd;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			n++;
			if (n > 100) timeout("bvalid");
			if (!aw_d && s_axi_awready === 1'b1) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready === 1'b1) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				done = 1'b1;
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] rd_d, output logic [1:0] resp);
		int n;
		logic ar_d, done;
		ar_d = 1'b0;
		done = 1'b0;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			n++;
			if (n > 100) timeout("rvalid");
			if (!ar_d && s_axi_arready === 1'b1) begin
				ar_d = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				done = 1'b1;
				rd_d = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [1:0] resp;
		axi_write(a, wd, resp);
		check("bresp", resp, tss_pkg::RESP_OKAY);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] rd_d;
		logic [1:0] resp;
		axi_read(a, rd_d, resp);
		check(name, rd_d, exp);
	endtask

	// poll the state field until the sequencer is back in idle
	task automatic wait_idle();
		logic [31:0] rd_d;
		logic [1:0] resp;
		int n;
		n = 0;
		do begin
			axi_read(tss_pkg::OFF_STAT, rd_d, resp);
			n++;
			if (n > 60) timeout("idle");
		end while (rd_d[6:4] !== 3'b001);
	endtask

	// stop first so every run starts at queue entry 0
	task automatic run(input logic [7:0] s [5], input logic [31:0] ctrl);
		wr(tss_pkg::OFF_CTRL, 32'h0);
		for (int i = 0; i < 5; i++) wr(tss_pkg::OFF_QUEUE + 8'(4 * i), 32'(s[i]));
		wr(tss_pkg::OFF_CTRL, ctrl);
	endtask

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// limit registers: reset value, then only sixteen bits kept
		for (int i = 0; i < 5; i++) rd(lim_offs[i], 32'(tss_pkg::RST_LIM), "lim_reset");
		for (int i = 0; i < 5; i++) begin
			wr(lim_offs[i], 32'hffffa5c3);
			rd(lim_offs[i], 32'h0000a5c3, "lim_width");
		end
		// queue entries are eight bits wide
		rd(tss_pkg::OFF_QUEUE, 32'(tss_pkg::RST_STEP), "queue_reset");
		for (int i = 0; i < 8; i++) begin
			wr(tss_pkg::OFF_QUEUE + 8'(4 * i), 32'h5a5a5a00 | i);
			rd(tss_pkg::OFF_QUEUE + 8'(4 * i), 32'(i), "queue_entry");
		end
		axi_read(8'h30, d, r);
		check("unmapped_resp", r, tss_pkg::RESP_SLVERR);
		axi_write(8'h30, 32'h0, r);
		check("unmapped_wresp", r, tss_pkg::RESP_SLVERR);
		// two output steps, gap between pulses at delay 0, 1 and 2
		for (int k = 0; k < 3; k++) begin
			wr(tss_pkg::OFF_SDLIM, 32'(k));
			run('{8'h20, 8'h21, 8'h80, 8'h80, 8'h80}, 32'h3);
			wait_idle();
			check("step_gap", 32'(periph.last_cyc[1] - periph.last_cyc[0]), 32'(k + 1));
		end
		// endless loop keeps it running while limits are written
		run('{8'h20, 8'h70, 8'h80, 8'h80, 8'h80}, 32'h3);
		wr(tss_pkg::OFF_SDLIM, 32'h7);
		wr(tss_pkg::OFF_C0LIM, 32'h7);
		rd(tss_pkg::OFF_SDLIM, 32'h2, "sdlim_locked");
		rd(tss_pkg::OFF_C0LIM, 32'ha5c3, "c0lim_locked");
		wr(tss_pkg::OFF_CTRL, 32'h1);
		wr(tss_pkg::OFF_SDLIM, 32'h0);
		rd(tss_pkg::OFF_SDLIM, 32'h0, "sdlim_free");
		// counter jump repeats step 0 limit plus one times
		wr(tss_pkg::OFF_C0LIM, 32'h2);
		base = periph.pulse_cnt[0];
		run('{8'h20, 8'h50, 8'h80, 8'h80, 8'h80}, 32'h3);
		wait_idle();
		check("loop_pulses", 32'(periph.pulse_cnt[0] - base), 32'h3);
		rd(tss_pkg::OFF_CTRL, 32'h1, "halt_ctrl");
		// rising then falling sensitivity on trigger line 2
		for (int m = 0; m < 2; m++) begin
			base = periph.pulse_cnt[3];
			run('{8'h12, 8'h23, 8'h80, 8'h80, 8'h80}, m ? 32'hb : 32'h3);
			periph.set_trig(2, 1'b1);
			repeat (8) @(posedge aclk);
			check("edge_first", 32'(periph.pulse_cnt[3] - base), m ? 32'h0 : 32'h1);
			periph.set_trig(2, 1'b0);
			wait_idle();
			check("edge_second", 32'(periph.pulse_cnt[3] - base), 32'h1);
		end
		// interrupt steps with single-step flag, masked then enabled
		wr(tss_pkg::OFF_IEN, 32'h0);
		run('{8'h30, 8'h31, 8'h32, 8'h33, 8'h80}, 32'h7);
		wait_idle();
		rd(tss_pkg::OFF_ISTAT, 32'h1f, "irq_status");
		check("irq_masked", {irq, step_irq}, 32'h0);
		wr(tss_pkg::OFF_IEN, 32'h3f);
		check("irq_enabled", {irq, step_irq}, 32'h1f);
		wr(tss_pkg::OFF_ICLR, 32'h1e);
		rd(tss_pkg::OFF_ISTAT, 32'h01, "irq_cleared");
		check("irq_partial", {irq, step_irq}, 32'h11);
		wr(tss_pkg::OFF_ICLR, 32'h3f);
		check("irq_none", {irq, step_irq}, 32'h0);
		run('{8'h30, 8'h31, 8'h32, 8'h33, 8'h80}, 32'h3);
		wait_idle();
		rd(tss_pkg::OFF_ISTAT, 32'h0f, "no_sstep");
		// timer wait of limit 3 lasts four cycles, plus one for the pulse step before it
		wr(tss_pkg::OFF_T0LIM, 32'h3);
		run('{8'h20, 8'h40, 8'h21, 8'h80, 8'h80}, 32'h3);
		wait_idle();
		check("timer_wait", 32'(periph.last_cyc[1] - periph.last_cyc[0]), 32'h5);
		// watchdog ends a wait that never completes
		wr(tss_pkg::OFF_ICLR, 32'h3f);
		wr(tss_pkg::OFF_WDLIM, 32'h5);
		run('{8'h10, 8'h80, 8'h80, 8'h80, 8'h80}, 32'h3);
		wait_idle();
		rd(tss_pkg::OFF_ISTAT, 32'h20, "wdt_status");
		check("wdt_irq", {31'h0, irq}, 32'h1);
		rd(tss_pkg::OFF_CTRL, 32'h1, "wdt_stop");
		end_sim();
	end
endmodule
`default_nettype wire
